// ==== design/rcw_defs.vh ====
`ifndef RCW_DEFS_VH
`define RCW_DEFS_VH

// ============================================================
// Register indices (byte address is four times the index)
`define RCW_IDX_CONFIG      8'h0A
`define RCW_IDX_NV_REF      8'h0F
`define RCW_IDX_UPPER_LIM   8'h10
`define RCW_IDX_ACTIVE_CFG  8'h27
`define RCW_IDX_SETPOINT    8'h2A
`define RCW_IDX_VOL_REF     8'h31

// ============================================================
// Configuration word fields
`define RCW_B_PERIODIC      1
`define RCW_B_OFFSET_COMP   2
`define RCW_B_JUMPER_EN     4
`define RCW_B_AUX_INV       5
`define RCW_B_FORCE_3PH     6
`define RCW_B_RAM_CTRL      7
`define RCW_B_VOLT_KNOB     8
`define RCW_B_STAB_KNOB     9
`define RCW_B_FREQ_KNOB     10
`define RCW_B_OVEREXC_KNOB  11
`define RCW_B_EXT_INPUT     12
`define RCW_B_EXT_DAC       13
`define RCW_B_SET_60HZ      14

// ============================================================
// Reset values
`define RCW_CONFIG_RST      16'h1F34
`define RCW_NV_REF_RST      15'h4000
`define RCW_UPPER_LIM_RST   15'h48F5
`define RCW_EXT_LIMIT_DEF   15'h7000

// ============================================================
// Reference source codes
`define RCW_SRC_ANALOG      2'h0
`define RCW_SRC_ANALOG_SAT  2'h1
`define RCW_SRC_NV_PARAM    2'h2
`define RCW_SRC_VOL_LOC     2'h3

`endif

// ==== design/rcw_config.v ====
// Operation
// - Each configuration bit except unused bits 0, 3 and 15: one enables, zero disables
// - Configuration word resets to 7988
// - Bit 2 offset compensation, single-phase only
// - Bit 4 reads jumper, else bit 14 picks 60Hz
// - Bit 12 enables analogue input, default on
// - Analogue plus bit 7 clamps at input limit
// - Saturated and link lost: go to upper limit
// - Digital bit 7 clear: follow nonvolatile reference
// - Volatile location writes ignored in that mode
// - Digital bit 7 set: follow volatile location
`include "rcw_defs.vh"
`default_nettype none

module rcw_config #(
   parameter [14:0] EXT_LIMIT     = `RCW_EXT_LIMIT_DEF,
   parameter [14:0] NV_REF_INIT   = `RCW_NV_REF_RST,
   parameter [14:0] UPPER_LIM_INIT = `RCW_UPPER_LIM_RST
) (
   input  wire        core_clk,
   input  wire        reset_n,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // Pins from the board
   input  wire        jumper_60hz,
   input  wire        three_phase_sense,
   input  wire        ext_link_ok,
   // Analogue control value from the converter logic on core_clk
   input  wire [14:0] ext_analog,
   // Function enables
   output reg         periodic_ref_en,
   output reg         offset_comp_en,
   output reg         nominal_60hz,
   output reg         aux_output_inversion,
   output reg         three_phase_active,
   output reg         voltage_knob_en,
   output reg         stability_knob_en,
   output reg         freq_knob_en,
   output reg         overexcitation_knob_en,
   output reg         ext_input_en,
   output reg         ext_dac_en,
   // Selected reference
   output reg  [1:0]  ref_source,
   output reg  [14:0] ref_setpoint
);

   // ============================================================
   // Helper functions

   function [1:0] src_sel;
      input [15:0] cfg;
      begin
         case ({cfg[`RCW_B_EXT_INPUT], cfg[`RCW_B_RAM_CTRL]})
            2'b10:   src_sel = `RCW_SRC_ANALOG;
            2'b11:   src_sel = `RCW_SRC_ANALOG_SAT;
            2'b00:   src_sel = `RCW_SRC_NV_PARAM;
            default: src_sel = `RCW_SRC_VOL_LOC;
         endcase
      end
   endfunction

   function [14:0] clamp;
      input [14:0] val;
      input [14:0] lim;
      begin
         clamp = (val > lim) ? lim : val;
      end
   endfunction

   // ============================================================
   // Pin synchronisers

   reg  [1:0] jumper_sync_q;
   reg  [1:0] three_ph_sync_q;
   reg  [1:0] link_sync_q;
   wire       jumper_s   = jumper_sync_q[1];
   wire       three_ph_s = three_ph_sync_q[1];
   wire       link_ok_s  = link_sync_q[1];

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         jumper_sync_q   <= 2'h0;
         three_ph_sync_q <= 2'h0;
         link_sync_q     <= 2'h0;
      end else begin
         jumper_sync_q   <= {jumper_sync_q[0], jumper_60hz};
         three_ph_sync_q <= {three_ph_sync_q[0], three_phase_sense};
         link_sync_q     <= {link_sync_q[0], ext_link_ok};
      end
   end

   // ============================================================
   // AHB-Lite address phase capture

   reg        wr_pend_q;
   reg  [7:0] wr_idx_q;
   wire       addr_ok  = hsel & hready & htrans[1];
   wire [7:0] addr_idx = haddr[9:2];

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= addr_ok & hwrite;
         wr_idx_q  <= addr_idx;
      end
   end

   // Zero wait states; every access completes OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ============================================================
   // Registers

   reg  [15:0] config_q;
   reg  [14:0] nv_ref_q;
   reg  [14:0] upper_lim_q;
   reg  [14:0] vol_ref_q;
   wire [1:0]  src_now = src_sel(config_q);
   wire        wr_cfg  = wr_pend_q & (wr_idx_q == `RCW_IDX_CONFIG);
   wire        wr_nv   = wr_pend_q & (wr_idx_q == `RCW_IDX_NV_REF);
   wire        wr_lim  = wr_pend_q & (wr_idx_q == `RCW_IDX_UPPER_LIM);
   wire        wr_vol  = wr_pend_q & (wr_idx_q == `RCW_IDX_VOL_REF);

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         config_q    <= `RCW_CONFIG_RST;
         nv_ref_q    <= NV_REF_INIT;
         upper_lim_q <= UPPER_LIM_INIT;
         // Volatile location starts from the stored reference
         vol_ref_q   <= NV_REF_INIT;
      end else begin
         if (wr_cfg)
            config_q <= hwdata[15:0];
         if (wr_nv)
            nv_ref_q <= hwdata[14:0];
         if (wr_lim)
            upper_lim_q <= hwdata[14:0];
         // Kept aligned to the stored value; supervisor writes dropped
         if (src_now == `RCW_SRC_NV_PARAM)
            vol_ref_q <= wr_nv ? hwdata[14:0] : nv_ref_q;
         else if (wr_vol)
            vol_ref_q <= hwdata[14:0];
      end
   end

   // ============================================================
   // Function enables and active configuration

   wire three_ph_d = config_q[`RCW_B_FORCE_3PH] | three_ph_s;
   // Offset compensation only meaningful with single-phase sensing
   wire offset_d   = config_q[`RCW_B_OFFSET_COMP] & ~three_ph_d;
   wire hz60_d     = config_q[`RCW_B_JUMPER_EN] ? jumper_s
                                                : config_q[`RCW_B_SET_60HZ];
   wire [15:0] active_cfg = {1'b0, hz60_d, config_q[13:7], three_ph_d,
                             config_q[5:4], 1'b0, offset_d, config_q[1], 1'b0};

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         periodic_ref_en        <= 1'b0;
         offset_comp_en         <= 1'b0;
         nominal_60hz           <= 1'b0;
         aux_output_inversion   <= 1'b0;
         three_phase_active     <= 1'b0;
         voltage_knob_en        <= 1'b0;
         stability_knob_en      <= 1'b0;
         freq_knob_en           <= 1'b0;
         overexcitation_knob_en <= 1'b0;
         ext_input_en           <= 1'b0;
         ext_dac_en             <= 1'b0;
      end else begin
         periodic_ref_en        <= config_q[`RCW_B_PERIODIC];
         offset_comp_en         <= offset_d;
         nominal_60hz           <= hz60_d;
         aux_output_inversion   <= config_q[`RCW_B_AUX_INV];
         three_phase_active     <= three_ph_d;
         voltage_knob_en        <= config_q[`RCW_B_VOLT_KNOB];
         stability_knob_en      <= config_q[`RCW_B_STAB_KNOB];
         freq_knob_en           <= config_q[`RCW_B_FREQ_KNOB];
         overexcitation_knob_en <= config_q[`RCW_B_OVEREXC_KNOB];
         ext_input_en           <= config_q[`RCW_B_EXT_INPUT];
         ext_dac_en             <= config_q[`RCW_B_EXT_DAC];
      end
   end

   // ============================================================
   // Reference selection

   reg [14:0] setpoint_d;

   always @* begin
      case (src_now)
         `RCW_SRC_ANALOG:
            // Without saturation the value may run past the input limit
            setpoint_d = ext_analog;
         `RCW_SRC_ANALOG_SAT:
            // Open control wire pushes to the upper limit, not to zero
            setpoint_d = link_ok_s ? clamp(ext_analog, EXT_LIMIT)
                                   : upper_lim_q;
         `RCW_SRC_NV_PARAM:
            setpoint_d = nv_ref_q;
         `RCW_SRC_VOL_LOC:
            setpoint_d = vol_ref_q;
         default:
            setpoint_d = nv_ref_q;
      endcase
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ref_source   <= `RCW_SRC_NV_PARAM;
         ref_setpoint <= 15'h0000;
      end else begin
         ref_source   <= src_now;
         ref_setpoint <= setpoint_d;
      end
   end

   // ============================================================
   // Read data, registered during the address phase

   reg [31:0] rd_d;

   always @* begin
      case (addr_idx)
         `RCW_IDX_CONFIG:     rd_d = {16'h0000, config_q};
         `RCW_IDX_NV_REF:     rd_d = {17'h00000, nv_ref_q};
         `RCW_IDX_UPPER_LIM:  rd_d = {17'h00000, upper_lim_q};
         `RCW_IDX_ACTIVE_CFG: rd_d = {16'h0000, active_cfg};
         `RCW_IDX_SETPOINT:   rd_d = {17'h00000, ref_setpoint};
         `RCW_IDX_VOL_REF:    rd_d = {17'h00000, vol_ref_q};
         default:             rd_d = 32'h00000000;
      endcase
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         hrdata <= 32'h00000000;
      else if (addr_ok & ~hwrite)
         hrdata <= (haddr[31:10] == 22'h000000) ? rd_d : 32'h00000000;
   end

endmodule // rcw_config

`default_nettype wire

// ==== sim/rcw_supervisor.sv ====
`default_nettype none
module rcw_supervisor (
   input  wire logic        core_clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output var  logic        hsel,
   output var  logic [31:0] haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Single word transfers only
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
   end
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge core_clk);
      while (hready !== 1'h1) begin
         n++;
         if (n > 64) tb_regulator_config_word_refsel.hang();
         @(posedge core_clk);
      end
   endtask
   // Writes to the volatile reference steer reactive power
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
      @(posedge core_clk);
      hsel   <= 1'h1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
      hsel <= 1'h0;
   endtask
endmodule // rcw_supervisor
`default_nettype wire

// ==== sim/rcw_config_properties.sv ====
`include "rcw_defs.vh"
`default_nettype none
module rcw_config_properties #(
   parameter logic [14:0] EXT_LIMIT      = `RCW_EXT_LIMIT_DEF,
   parameter logic [14:0] NV_REF_INIT    = `RCW_NV_REF_RST,
   parameter logic [14:0] UPPER_LIM_INIT = `RCW_UPPER_LIM_RST
) (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        three_phase_sense,
   input wire logic        ext_link_ok,
   input wire logic [14:0] ext_analog,
   input wire logic        offset_comp_en,
   input wire logic        three_phase_active,
   input wire logic        ext_input_en,
   input wire logic        voltage_knob_en,
   input wire logic [1:0]  ref_source,
   input wire logic [14:0] ref_setpoint
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Link history covers the pin synchroniser delay
   logic [3:0] link_hist_q;
   always @(posedge core_clk or negedge reset_n)
      if (!reset_n) link_hist_q <= 4'h0;
      else link_hist_q <= {link_hist_q[2:0], ext_link_ok};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   AST_RESET_DEFAULT: assert property ($rose(reset_n) |=> ext_input_en && voltage_knob_en && ref_source == 2'h0)
      else $error("bad defaults after reset");
   AST_SOURCE_MAP: assert property (ext_input_en == !ref_source[1])
      else $error("source disagrees with analogue enable");
   AST_OFFSET_1PH: assert property (three_phase_active && $past(three_phase_active) |-> !offset_comp_en)
      else $error("offset compensation in three phase");
   AST_3PH_SENSE: assert property (three_phase_sense [*3] |=> three_phase_active)
      else $error("three phase sensing not active");
   AST_NV_REF: assert property (ref_source == 2'h2 && $past(reset_n) |-> ref_setpoint == NV_REF_INIT)
      else $error("setpoint not stored reference");
   AST_ANALOG_PASS: assert property (ref_source == 2'h0 && $past(ref_source) == 2'h0 |-> ref_setpoint == $past(ext_analog))
      else $error("analogue value not passed");
   AST_SAT_CLAMP: assert property (ref_source == 2'h1 && ext_link_ok && &link_hist_q |-> ref_setpoint == (($past(ext_analog) > EXT_LIMIT) ? EXT_LIMIT : $past(ext_analog)))
      else $error("saturation clamp wrong");
   AST_SAT_LOST: assert property (ref_source == 2'h1 && !ext_link_ok && ~|link_hist_q |-> ref_setpoint == UPPER_LIM_INIT)
      else $error("link loss not at upper limit");
endmodule // rcw_config_properties
bind rcw_config rcw_config_properties #(.EXT_LIMIT(EXT_LIMIT), .NV_REF_INIT(NV_REF_INIT),
   .UPPER_LIM_INIT(UPPER_LIM_INIT)) rcw_config_properties_i (.*);
`default_nettype wire

// ==== sim/tb_regulator_config_word_refsel.sv ====
`include "rcw_defs.vh"
`default_nettype none
module tb_regulator_config_word_refsel;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'h0, reset_n = 1'h0, jumper_60hz = 1'h0;
   logic        three_phase_sense = 1'h0, ext_link_ok = 1'h1;
   logic [14:0] ext_analog = 15'h0000;
   logic [31:0] q;
   wire         hsel, hwrite, hready, hreadyout, hresp;
   wire  [31:0] haddr, hwdata, hrdata;
   wire  [1:0]  htrans, ref_source;
   wire  [2:0]  hsize;
   wire  [14:0] ref_setpoint;
   wire         periodic_ref_en, offset_comp_en, nominal_60hz, aux_output_inversion;
   wire         three_phase_active, voltage_knob_en, stability_knob_en, freq_knob_en;
   wire         overexcitation_knob_en, ext_input_en, ext_dac_en;
   wire  [7:0]  en_w = {ext_dac_en, ext_input_en, overexcitation_knob_en, freq_knob_en,
                         stability_knob_en, voltage_knob_en, aux_output_inversion, periodic_ref_en};
   int          fails = 0, checked = 0;
   assign hready = hreadyout;
   always #4 core_clk = ~core_clk;
   rcw_config     rcw_config_i (.*);
   rcw_supervisor rcw_supervisor_i (.*);
   // ==========================================================
   // Helpers
   task automatic check(input string name, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic hang;
      fails++;
      end_of_test();
   endtask
   // Pin inputs need two synchroniser edges on top of the register edge
   task automatic settle;
      repeat (5) @(posedge core_clk);
   endtask
   task automatic wr(input logic [31:0] a, d);
      rcw_supervisor_i.xfer(1'h1, a, d, q);
      settle();
   endtask
   task automatic rd(input logic [31:0] a);
      rcw_supervisor_i.xfer(1'h0, a, 32'h0, q);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd(32'h28);
      check("config", q, {16'h0, `RCW_CONFIG_RST});
      rd(32'hC4);
      check("volatile ref", q, 32'h4000);
      rd(32'h3FC);
      check("unmapped", q, 32'h0);
   endtask
   task automatic t_bits;
      logic [15:0] w;
      for (int b = 0; b < 16; b++) begin
         w = 16'h1 << b;
         wr(32'h28, {16'h0, w});
         check("enables", en_w, {w[13:8], w[5], w[1]});
         rd(32'h28);
         check("readback", q, {16'h0, w});
      end
   endtask
   task automatic t_freq;
      jumper_60hz <= 1'h1;
      wr(32'h28, 32'h10);
      check("jumper 60", nominal_60hz, 1'h1);
      jumper_60hz <= 1'h0;
      wr(32'h28, 32'h4000);
      check("override 60", nominal_60hz, 1'h1);
      wr(32'h28, 32'h4010);
      check("jumper 50", nominal_60hz, 1'h0);
   endtask
   task automatic t_offset;
      wr(32'h28, 32'h4);
      check("offset 1ph", {offset_comp_en, three_phase_active}, 2'h2);
      three_phase_sense <= 1'h1;
      settle();
      check("offset 3ph", {offset_comp_en, three_phase_active}, 2'h1);
      three_phase_sense <= 1'h0;
      wr(32'h28, 32'h44);
      check("forced 3ph", {offset_comp_en, three_phase_active}, 2'h1);
   endtask
   task automatic t_sat;
      ext_analog <= 15'h7FFF;
      wr(32'h28, 32'h1080);
      check("clamp", {ref_source, ref_setpoint}, {2'h1, `RCW_EXT_LIMIT_DEF});
      ext_link_ok <= 1'h0;
      settle();
      check("link lost", ref_setpoint, `RCW_UPPER_LIM_RST);
      wr(32'h28, 32'h1000);
      check("no clamp", {ref_source, ref_setpoint}, {2'h0, 15'h7FFF});
      ext_link_ok <= 1'h1;
   endtask
   task automatic t_digital;
      wr(32'h28, 32'h0);
      wr(32'hC4, 32'h1234);
      check("nv mode", {ref_source, ref_setpoint}, {2'h2, `RCW_NV_REF_RST});
      rd(32'hC4);
      check("nv follow", q, 32'h4000);
      wr(32'h28, 32'h80);
      wr(32'hC4, 32'h1234);
      check("ram mode", {ref_source, ref_setpoint}, {2'h3, 15'h1234});
   endtask
   task automatic t_status;
      wr(32'h28, 32'h9F3D);
      check("unused bits", en_w, 8'h7E);
      rd(32'h9C);
      check("active 1ph 50", q, 32'h1F34);
      rd(32'hA8);
      check("setpoint read", q, 32'h7FFF);
      three_phase_sense <= 1'h1;
      jumper_60hz       <= 1'h1;
      settle();
      rd(32'h9C);
      check("active 3ph 60", q, 32'h5F70);
      three_phase_sense <= 1'h0;
      jumper_60hz       <= 1'h0;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'h1;
      t_reset();
      t_bits();
      t_freq();
      t_offset();
      t_sat();
      t_digital();
      t_status();
      end_of_test();
   end
endmodule // tb_regulator_config_word_refsel
`default_nettype wire
